// [hdl/pixel_unpacker.sv]
// encoder-side input pixel unpacker
// --------------------------------------------------------------------
// Behaviour
// - multiplex select 0 unitary, 1 two-word
// - RGB555 default takes 20:16, 12:8, 4:0
// - order 110 packs fields contiguously
// - order 111 green from D14 and 11:8
// - orders 001-101 permute colour components
// - reversal flips data bits, ones stay at low end
// - upper alignment takes 23:19, 15:11, 7:3
// - 4:2:2 order bit0 swaps luma, chroma bytes
// - 4:2:2 reversal flips luma and chroma bytes
// - 4:2:2 upper alignment uses D[23:8]
// - 4:4:4 order codes select byte order
// - 4:4:4 reversal flips each byte
// - muxed RGB12 split over two words
// - muxed 8-bit 4:2:2 ordered and reversed
// - first chroma Cr when order select 0
// - two words per pixel make one pixel
// - word after hsync edge is first word
// - controller sends Cb Y Cr Y co-sited
// - controller blanks with 0 or 16/128
// - run-in code realigns off-by-one pairs
// --------------------------------------------------------------------
`timescale 1ns/1ps
module pixel_unpacker
   import tv_input_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   pixel_link_if.device     link,
   input  wire logic        multiplex_i,
   input  wire logic [2:0]  input_format_select_i,
   input  wire logic [2:0]  channel_order_i,
   input  wire logic        bit_reverse_i,
   input  wire logic        upper_align_i,
   input  wire logic        chroma_order_select_i,
   input  wire logic        embedded_sync_i,
   output logic      [23:0] pixel_o,
   output logic             pixel_valid_o
);

   // ------------------------------------------------------------------
   // pin sampling
   // ------------------------------------------------------------------
   logic                s_clk;
   logic                s_hs;
   logic [DATA_W-1:0]   s_d;
   logic                clk_prev;
   logic                link_edge;

   // pins change well away from the link rising edge, so one bundle
   // synchroniser keeps clock, sync and data aligned
   sync_2ff #(
      .W (DATA_W + 2)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     ({link.input_pixel_clock, link.hsync, link.data}),
      .q_o     ({s_clk, s_hs, s_d})
   );

   assign link_edge = s_clk & ~clk_prev;

   // ------------------------------------------------------------------
   // unitary decode
   // ------------------------------------------------------------------
   logic [4:0]  f0;
   logic [4:0]  f1;
   logic [4:0]  f2;
   logic [15:0] yc_word;
   logic [23:0] uni_pix;
   logic [7:0]  uni_luma;
   logic [7:0]  uni_chroma;
   logic [23:0] yc444;

   always_comb begin
      if (upper_align_i) begin
         f0 = s_d[23:19];
         f1 = s_d[15:11];
         f2 = s_d[7:3];
      end else begin
         case (channel_order_i)
            ORDER_PACKED: begin
               f0 = s_d[14:10];
               f1 = s_d[9:5];
               f2 = s_d[4:0];
            end
            ORDER_SPLIT_GRN: begin
               f0 = s_d[20:16];
               f1 = {s_d[14], s_d[11:8]};
               f2 = s_d[4:0];
            end
            default: begin
               f0 = s_d[20:16];
               f1 = s_d[12:8];
               f2 = s_d[4:0];
            end
         endcase
      end
      yc_word    = upper_align_i ? s_d[23:8] : s_d[15:0];
      uni_luma   = rev_if(channel_order_i[0] ? yc_word[7:0] : yc_word[15:8],
                          bit_reverse_i);
      uni_chroma = rev_if(channel_order_i[0] ? yc_word[15:8] : yc_word[7:0],
                          bit_reverse_i);
      yc444      = permute(rev_if(s_d[23:16], bit_reverse_i),
                           rev_if(s_d[15:8], bit_reverse_i),
                           rev_if(s_d[7:0], bit_reverse_i),
                           channel_order_i);
      case (input_format_select_i)
         FMT_RGB555: uni_pix = permute(pad5(f0, bit_reverse_i), pad5(f1, bit_reverse_i),
                                       pad5(f2, bit_reverse_i), channel_order_i);
         FMT_YC444:  uni_pix = {yc444[23:16], yc444[7:0], yc444[15:8]};
         FMT_RGB24:  uni_pix = yc444;
         default:    uni_pix = s_d;
      endcase
   end

   // ------------------------------------------------------------------
   // word pairing, realignment and pixel register
   // ------------------------------------------------------------------
   word_phase_t        phase;
   word_phase_t        next_phase;
   logic [WORD_W-1:0]  word_a;
   logic [WORD_W-1:0]  next_word_a;
   logic [23:0]        hist;
   logic [23:0]        next_hist;
   logic               hs_prev;
   logic               next_hs_prev;
   logic               chroma_ph;
   logic               next_chroma_ph;
   logic [7:0]         cb_hold;
   logic [7:0]         next_cb_hold;
   logic [7:0]         cr_hold;
   logic [7:0]         next_cr_hold;
   logic [23:0]        next_pixel;
   logic               next_valid;
   logic               emit;
   logic               emit_yc;
   logic [7:0]         e_luma;
   logic [7:0]         e_chroma;
   logic [23:0]        e_pix;
   logic               runin_hit;
   logic [7:0]         mux_a;
   logic [7:0]         mux_b;

   always_comb begin
      next_phase     = phase;
      next_word_a    = word_a;
      next_hist      = hist;
      next_hs_prev   = hs_prev;
      next_chroma_ph = chroma_ph;
      next_cb_hold   = cb_hold;
      next_cr_hold   = cr_hold;
      next_pixel     = pixel_o;
      next_valid     = 1'b0;
      emit           = 1'b0;
      emit_yc        = 1'b0;
      e_luma         = uni_luma;
      e_chroma       = uni_chroma;
      e_pix          = uni_pix;
      mux_a          = rev_if(word_a[7:0], bit_reverse_i);
      mux_b          = rev_if(s_d[7:0], bit_reverse_i);
      runin_hit      = multiplex_i && embedded_sync_i &&
                       (input_format_select_i == FMT_YC422) && (hist == RUNIN_PREFIX);
      if (link_edge) begin
         next_hs_prev = s_hs;
         next_hist    = {hist[15:0], s_d[7:0]};
         if (s_hs && !hs_prev) begin
            // the sync word is dropped; the next word opens a pixel
            next_phase     = WORD_A;
            next_chroma_ph = 1'b0;
         end else if (!multiplex_i) begin
            emit    = 1'b1;
            emit_yc = (input_format_select_i == FMT_YC422);
         end else if (runin_hit) begin
            // status word of the run-in code; a pair starts after it
            next_phase = WORD_A;
         end else if (phase == WORD_A) begin
            next_word_a = s_d[WORD_W-1:0];
            next_phase  = WORD_B;
         end else begin
            next_phase = WORD_A;
            emit       = 1'b1;
            if (input_format_select_i == FMT_YC422) begin
               emit_yc  = 1'b1;
               e_luma   = channel_order_i[0] ? mux_a : mux_b;
               e_chroma = channel_order_i[0] ? mux_b : mux_a;
            end else if (input_format_select_i == FMT_MUX_RGB12) begin
               e_pix = {s_d[11:4], s_d[3:0], word_a[11:8], word_a[7:0]};
            end else begin
               e_pix = {s_d[WORD_W-1:0], word_a};
            end
         end
      end
      if (emit) begin
         next_valid = 1'b1;
         if (emit_yc) begin
            if (chroma_ph ^ chroma_order_select_i) begin
               next_cb_hold = e_chroma;
            end else begin
               next_cr_hold = e_chroma;
            end
            next_chroma_ph = ~chroma_ph;
            next_pixel     = {e_luma, next_cb_hold, next_cr_hold};
         end else begin
            next_pixel = e_pix;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk_prev      <= 1'b0;
         phase         <= WORD_A;
         word_a        <= '0;
         hist          <= '0;
         hs_prev       <= 1'b0;
         chroma_ph     <= 1'b0;
         cb_hold       <= '0;
         cr_hold       <= '0;
         pixel_o       <= '0;
         pixel_valid_o <= 1'b0;
      end else begin
         clk_prev      <= s_clk;
         phase         <= next_phase;
         word_a        <= next_word_a;
         hist          <= next_hist;
         hs_prev       <= next_hs_prev;
         chroma_ph     <= next_chroma_ph;
         cb_hold       <= next_cb_hold;
         cr_hold       <= next_cr_hold;
         pixel_o       <= next_pixel;
         pixel_valid_o <= next_valid;
      end
   end

endmodule // pixel_unpacker

// [hdl/tv_input_pkg.sv]
// shared constants, types and mapping functions of the pixel input link
package tv_input_pkg;

   // ------------------------------------------------------------------
   // link widths
   // ------------------------------------------------------------------
   localparam int DATA_W = 24;
   localparam int WORD_W = 12;

   // ------------------------------------------------------------------
   // input format codes and channel order codes
   // ------------------------------------------------------------------
   localparam logic [2:0] FMT_RGB24       = 3'h0;
   localparam logic [2:0] FMT_MUX_RGB12   = 3'h0;
   localparam logic [2:0] FMT_RGB555      = 3'h4;
   localparam logic [2:0] FMT_YC422       = 3'h5;
   localparam logic [2:0] FMT_YC444       = 3'h6;
   localparam logic [2:0] ORDER_PACKED    = 3'h6;
   localparam logic [2:0] ORDER_SPLIT_GRN = 3'h7;
   localparam logic [2:0] PAD_ONES        = 3'h7;

   // ------------------------------------------------------------------
   // embedded sync run-in code
   // ------------------------------------------------------------------
   localparam logic [23:0] RUNIN_PREFIX = 24'hFF0000;

   // ------------------------------------------------------------------
   // controller register map
   // ------------------------------------------------------------------
   localparam logic [7:0]  OFF_CTRL        = 8'h00;
   localparam logic [7:0]  OFF_PIXEL       = 8'h04;
   localparam logic [7:0]  OFF_LINE        = 8'h08;
   localparam logic [7:0]  OFF_BLANK       = 8'h0C;
   localparam logic [7:0]  OFF_STATUS      = 8'h10;
   localparam int          CTRL_RUN_BIT    = 0;
   localparam int          CTRL_MUX_BIT    = 1;
   localparam int          STAT_PEND_BIT   = 0;
   localparam int          STAT_PAIR_BIT   = 1;
   localparam logic [1:0]  CTRL_RESET      = 2'h0;
   localparam logic [23:0] BLANK_RESET     = 24'h000000;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 10;
   localparam int LINK_PERIOD_NS   = 80;
   localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

   typedef enum logic {WORD_A = 1'b0, WORD_B = 1'b1} word_phase_t;

   // ------------------------------------------------------------------
   // mapping helpers
   // ------------------------------------------------------------------
   function automatic logic [7:0] bitrev8(input logic [7:0] v);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) begin
         r[i] = v[7 - i];
      end
      return r;
   endfunction

   function automatic logic [7:0] rev_if(input logic [7:0] v, input logic rev);
      return rev ? bitrev8(v) : v;
   endfunction

   // five data bits padded with ones; reversal flips the data bits and keeps the ones at the low end
   function automatic logic [7:0] pad5(input logic [4:0] f, input logic rev);
      return rev ? bitrev8({PAD_ONES, f}) : {f, PAD_ONES};
   endfunction

   // fields x0,x1,x2 in bus order; result is {c0,c1,c2} = {R,G,B} or {Y,Cr,Cb}
   function automatic logic [23:0] permute(input logic [7:0] x0, input logic [7:0] x1,
                                           input logic [7:0] x2, input logic [2:0] order);
      case (order)
         3'h1:    return {x0, x2, x1};
         3'h2:    return {x1, x0, x2};
         3'h3:    return {x2, x0, x1};
         3'h4:    return {x1, x2, x0};
         3'h5:    return {x2, x1, x0};
         default: return {x0, x1, x2};
      endcase
   endfunction

endpackage

// [hdl/pixel_link_if.sv]
// pixel bus between the graphics controller and the encoder input
`timescale 1ns/1ps
interface pixel_link_if;
   logic        input_pixel_clock;
   logic        hsync;
   logic [23:0] data;

   modport device (input input_pixel_clock, input hsync, input data);
   modport source (output input_pixel_clock, output hsync, output data);
endinterface

// [hdl/sync_2ff.sv]
// two-flop synchroniser for a bundle of pins
`timescale 1ns/1ps
module sync_2ff #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   always_comb begin
      next_meta = d_i;
      next_q    = meta;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= '0;
         q_o  <= '0;
      end else begin
         meta <= next_meta;
         q_o  <= next_q;
      end
   end
endmodule // sync_2ff

// [hdl/pixel_source.sv]
// controller-side pixel source with an apb register port
`timescale 1ns/1ps
module pixel_source
   import tv_input_pkg::*;
#(
   parameter int HALF_CYCLES = LINK_HALF_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   pixel_link_if.source     link
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic [1:0]        ctrl;
   logic [1:0]        next_ctrl;
   logic [23:0]       blank;
   logic [23:0]       next_blank;
   logic              pend_valid;
   logic              next_pend_valid;
   logic              pend_line;
   logic              next_pend_line;
   logic [23:0]       pend_data;
   logic [23:0]       next_pend_data;
   logic [7:0]        div_cnt;
   logic [7:0]        next_div_cnt;
   logic              pclk;
   logic              next_pclk;
   logic              hs;
   logic              next_hs;
   logic [23:0]       dout;
   logic [23:0]       next_dout;
   word_phase_t       phase;
   word_phase_t       next_phase;
   logic [WORD_W-1:0] word_b;
   logic [WORD_W-1:0] next_word_b;
   logic [31:0]       next_prdata;
   logic              next_pready;
   logic              next_pslverr;
   logic              queue_hit;
   logic              mapped;
   logic              done;
   logic              wrap;
   logic [23:0]       src;

   assign link.input_pixel_clock = pclk;
   assign link.hsync             = hs;
   assign link.data              = dout;

   // ------------------------------------------------------------------
   // apb slave and link driver
   // ------------------------------------------------------------------
   always_comb begin
      next_ctrl       = ctrl;
      next_blank      = blank;
      next_pend_valid = pend_valid;
      next_pend_line  = pend_line;
      next_pend_data  = pend_data;
      next_div_cnt    = div_cnt;
      next_pclk       = pclk;
      next_hs         = hs;
      next_dout       = dout;
      next_phase      = phase;
      next_word_b     = word_b;
      next_prdata     = prdata_o;
      next_pready     = 1'b0;
      next_pslverr    = 1'b0;
      mapped          = (paddr_i == OFF_CTRL) || (paddr_i == OFF_PIXEL) ||
                        (paddr_i == OFF_LINE) || (paddr_i == OFF_BLANK) ||
                        (paddr_i == OFF_STATUS);
      queue_hit       = pwrite_i && ((paddr_i == OFF_PIXEL) || (paddr_i == OFF_LINE));
      done            = psel_i && penable_i && pready_o;
      // a full slot holds the bus off until the link takes the word
      if (psel_i && penable_i && !pready_o && !(queue_hit && pend_valid)) begin
         next_pready  = 1'b1;
         next_pslverr = !mapped;
         next_prdata  = 32'h00000000;
         if (!pwrite_i) begin
            case (paddr_i)
               OFF_CTRL:   next_prdata = {30'h00000000, ctrl};
               OFF_BLANK:  next_prdata = {8'h00, blank};
               OFF_STATUS: next_prdata = {30'h00000000, phase == WORD_B, pend_valid};
               default:    next_prdata = 32'h00000000;
            endcase
         end
      end
      if (done && pwrite_i) begin
         case (paddr_i)
            OFF_CTRL:  next_ctrl = pwdata_i[1:0];
            OFF_BLANK: next_blank = pwdata_i[23:0];
            OFF_PIXEL: begin
               next_pend_valid = 1'b1;
               next_pend_line  = 1'b0;
               next_pend_data  = pwdata_i[23:0];
            end
            OFF_LINE: begin
               next_pend_valid = 1'b1;
               next_pend_line  = 1'b1;
            end
            default: next_ctrl = ctrl;
         endcase
      end
      wrap = (div_cnt == 8'(HALF_CYCLES - 1));
      src  = pend_valid ? pend_data : blank;
      if (!ctrl[CTRL_RUN_BIT]) begin
         next_div_cnt = 8'h00;
         next_pclk    = 1'b0;
      end else if (!wrap) begin
         next_div_cnt = div_cnt + 8'h01;
      end else begin
         next_div_cnt = 8'h00;
         next_pclk    = ~pclk;
         // words change on the falling link edge, away from sampling
         if (pclk) begin
            next_hs = 1'b0;
            if (phase == WORD_B) begin
               next_dout  = {12'h000, word_b};
               next_phase = WORD_A;
            end else if (pend_valid && pend_line) begin
               // pair boundary only, so the first word after it opens a pixel
               next_pend_valid = 1'b0;
               next_hs         = 1'b1;
               next_dout       = 24'h000000;
            end else begin
               next_pend_valid = next_pend_valid & ~pend_valid;    // a landing write wins
               if (ctrl[CTRL_MUX_BIT]) begin
                  next_dout   = {12'h000, src[WORD_W-1:0]};
                  next_word_b = src[23:WORD_W];
                  next_phase  = WORD_B;
               end else begin
                  next_dout = src;
               end
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl       <= CTRL_RESET;
         blank      <= BLANK_RESET;
         pend_valid <= 1'b0;
         pend_line  <= 1'b0;
         pend_data  <= '0;
         div_cnt    <= 8'h00;
         pclk       <= 1'b0;
         hs         <= 1'b0;
         dout       <= '0;
         phase      <= WORD_A;
         word_b     <= '0;
         prdata_o   <= 32'h00000000;
         pready_o   <= 1'b0;
         pslverr_o  <= 1'b0;
      end else begin
         ctrl       <= next_ctrl;
         blank      <= next_blank;
         pend_valid <= next_pend_valid;
         pend_line  <= next_pend_line;
         pend_data  <= next_pend_data;
         div_cnt    <= next_div_cnt;
         pclk       <= next_pclk;
         hs         <= next_hs;
         dout       <= next_dout;
         phase      <= next_phase;
         word_b     <= next_word_b;
         prdata_o   <= next_prdata;
         pready_o   <= next_pready;
         pslverr_o  <= next_pslverr;
      end
   end

endmodule // pixel_source

// [test/pixel_link_properties.sv]
// timing checks on the pixel link and the unpacked pixel output
`timescale 1ns/1ps
module pixel_link_properties (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        input_pixel_clock,
   input  wire logic        hsync,
   input  wire logic [23:0] data,
   input  wire logic [23:0] pixel_o,
   input  wire logic        pixel_valid_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // saturating count of cycles since the link clock was seen rising
   logic       prev_clk;
   logic [3:0] since_rise;
   logic [3:0] next_since_rise;
   always_comb begin
      next_since_rise = (since_rise == 4'hF) ? since_rise : since_rise + 4'h1;
      if (input_pixel_clock && !prev_clk) next_since_rise = 4'h0;
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_clk   <= 1'b0;
         since_rise <= 4'hF;
      end else begin
         prev_clk   <= input_pixel_clock;
         since_rise <= next_since_rise;
      end
   end

   // half period fixed at four cycles by the bench
   sequence link_high_phase;
      input_pixel_clock [*4];
   endsequence
   sequence link_low_phase;
      !input_pixel_clock [*4];
   endsequence

   chk_clk_high_len:
      assert property ($rose(input_pixel_clock) |-> link_high_phase ##1 !input_pixel_clock)
      else $error("link clock high phase wrong");
   chk_clk_low_len:
      assert property ($fell(input_pixel_clock) |-> link_low_phase) else $error("low phase short");
   chk_data_on_fall:
      assert property ($changed(data) |-> $fell(input_pixel_clock)) else $error("data moved");
   chk_hsync_on_fall:
      assert property ($changed(hsync) |-> $fell(input_pixel_clock)) else $error("hsync moved");
   chk_hsync_width:
      assert property ($rose(hsync) |-> hsync [*8] ##1 !hsync) else $error("hsync width");
   chk_valid_pulse:
      assert property (pixel_valid_o |=> !pixel_valid_o) else $error("valid too long");
   chk_valid_after_rise:
      assert property (pixel_valid_o |-> since_rise inside {[1:5]}) else $error("valid late");
   chk_pixel_hold:
      assert property ($changed(pixel_o) |-> pixel_valid_o) else $error("pixel moved");
endmodule // pixel_link_properties

// [test/input_pixel_format_unpacker_tb.sv]
// self-checking bench for the pixel source and unpacker pair
`timescale 1ns/1ps
module input_pixel_format_unpacker_tb;
   import tv_input_pkg::*;
   logic        clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [7:0]  paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rdat;
   logic        pready_o, pslverr_o, rerr, pixel_valid_o, seen;
   logic        multiplex_i = 0, bit_reverse_i = 0, upper_align_i = 0;
   logic        chroma_order_select_i = 0, embedded_sync_i = 0;
   logic [2:0]  input_format_select_i = 3'h0, channel_order_i = 3'h0;
   logic [23:0] pixel_o, d, q, m;
   int          errors = 0, tests_run = 0, k, j;
   pixel_link_if link ();
   always #5 clk_i = ~clk_i;
   pixel_source #(.HALF_CYCLES(4)) u_pixel_source (.clk_i, .rst_n_i, .psel_i, .penable_i,
      .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .link(link));
   pixel_unpacker u_pixel_unpacker (.clk_i, .rst_n_i, .link(link), .multiplex_i,
      .input_format_select_i, .channel_order_i, .bit_reverse_i, .upper_align_i,
      .chroma_order_select_i, .embedded_sync_i, .pixel_o, .pixel_valid_o);
   pixel_link_properties u_pixel_link_properties (.clk_i, .rst_n_i, .pixel_o, .pixel_valid_o,
      .input_pixel_clock(link.input_pixel_clock), .hsync(link.hsync), .data(link.data));
   // ----
   // reference mapping
   // ----
   function automatic logic [7:0] rv(input logic [7:0] v);
      return bit_reverse_i ? {<<{v}} : v;
   endfunction
   function automatic logic [7:0] p5(input logic [4:0] v);
      return bit_reverse_i ? {<<{{3'h7, v}}} : {v, 3'h7};
   endfunction
   function automatic logic [23:0] perm(input logic [7:0] a, b, c);
      case (channel_order_i)
         3'h1: return {a, c, b};
         3'h2: return {b, a, c};
         3'h3: return {c, a, b};
         3'h4: return {b, c, a};
         3'h5: return {c, b, a};
         default: return {a, b, c};
      endcase
   endfunction
   // constant blank word, so both chroma slots end up equal
   function automatic logic [23:0] expect_px(input logic [23:0] w);
      logic [15:0] b;
      logic [14:0] f;
      logic [23:0] c;
      b = multiplex_i ? {w[19:12], w[7:0]} : upper_align_i ? w[23:8] : w[15:0];
      f = channel_order_i == 3'h6 ? w[14:0] : channel_order_i == 3'h7 ?
          {w[20:16], w[14], w[11:8], w[4:0]} : upper_align_i ?
          {w[23:19], w[15:11], w[7:3]} : {w[20:16], w[12:8], w[4:0]};
      if (multiplex_i && input_format_select_i == FMT_MUX_RGB12) return w;
      if (input_format_select_i == FMT_YC422) begin
         c[23:16] = rv(channel_order_i[0] ? b[7:0] : b[15:8]);
         c[15:0] = {2{rv(channel_order_i[0] ? b[15:8] : b[7:0])}};
         return c;
      end
      if (input_format_select_i == FMT_YC444) begin
         c = perm(rv(w[23:16]), rv(w[15:8]), rv(w[7:0]));
         return {c[23:16], c[7:0], c[15:8]};
      end
      return perm(p5(f[14:10]), p5(f[9:5]), p5(f[4:0]));
   endfunction
   // ----
   // bench tasks
   // ----
   task automatic chk(input string n, input logic [23:0] s, e);
      tests_run++;
      if (s !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic results;
      if (errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n = 0;
      @(posedge clk_i);
      psel_i    <= 1'b1;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 2000);
      if (n >= 2000) begin
         errors++;
         results;
      end
      rdat = prdata_o;
      rerr = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wv(input int n);
      int c = 0;
      while (n > 0) begin
         @(posedge clk_i);
         if (pixel_valid_o === 1'b1) n--;
         if (++c > 400) begin
            errors++;
            results;
         end
      end
   endtask
   // ----
   // stimulus
   // ----
   initial begin
      rdat = $urandom(32'h64EB);
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      chk("pixel_rst", pixel_o, 24'h0);
      apb(1'b0, OFF_CTRL, 32'h0);
      chk("ctrl_rst", rdat[23:0], {22'h0, CTRL_RESET});
      apb(1'b0, OFF_BLANK, 32'h0);
      chk("blank_rst", rdat[23:0], BLANK_RESET);
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped", {rerr, rdat[22:0]}, 24'h800000);
      // each of the six format cases runs six times; RGB555 visits orders 0-3, 6 and 7, the YC cases orders 0-5
      for (int i = 0; i < 36; i++) begin
         k = i % 6;
         j = i / 6;
         d = 24'($urandom);
         if (k == 5) d = d & 24'h0FF0FF;
         multiplex_i <= (k > 3);
         case (k)
            0, 1: input_format_select_i <= FMT_RGB555;
            2, 5: input_format_select_i <= FMT_YC422;
            3: input_format_select_i <= FMT_YC444;
            default: input_format_select_i <= FMT_MUX_RGB12;
         endcase
         channel_order_i <= (k == 0 && j > 3) ? 3'(j + 2) : (k == 1 || k == 4) ? 3'h0 : 3'(j);
         bit_reverse_i <= (k == 1 || k == 4) ? 1'b0 : 1'($urandom);
         upper_align_i <= (k == 1) || (k == 2 && 1'($urandom));
         chroma_order_select_i <= 1'($urandom);
         embedded_sync_i <= (k == 5);
         apb(1'b1, OFF_CTRL, {30'h0, k > 3, 1'b1});
         apb(1'b1, OFF_BLANK, {8'h0, d});
         apb(1'b0, OFF_BLANK, 32'h0);
         chk("blank_rw", rdat[23:0], d);
         apb(1'b1, OFF_LINE, 32'h0);
         wv(4);
         chk("pixel", pixel_o, expect_px(d));
         if (k != 2 && k != 5) begin
            d = 24'($urandom);
            apb(1'b1, OFF_PIXEL, {8'h0, d});
            seen = 1'b0;
            for (int n = 0; n < 6; n++) begin
               wv(1);
               seen |= (pixel_o === expect_px(d));
            end
            chk("queued", {23'h0, seen}, 24'h1);
         end else begin
            q = expect_px(d);
            m = {8'hFF, {8{chroma_order_select_i}}, {8{!chroma_order_select_i}}};
            d = 24'($urandom) & 24'h0FF0FF;
            apb(1'b1, OFF_LINE, 32'h0);
            apb(1'b1, OFF_PIXEL, {8'h0, d});
            wv(1);
            chk("chroma_first", pixel_o, (expect_px(d) & m) | (q & ~m));
         end
         if (k == 5) begin
            apb(1'b1, OFF_PIXEL, 32'h0000FF);
            apb(1'b1, OFF_PIXEL, 32'h080000);
            apb(1'b1, OFF_PIXEL, 32'h05A05A);
            wv(1);
            chk("runin", pixel_o & 24'hFF0000, 24'h5A0000);
         end
      end
      results;
   end
endmodule // input_pixel_format_unpacker_tb
